// ---- logic/dbapr_pkg.sv ----
package dbapr_pkg;
  localparam int unsigned NUM_BG = 4;
  localparam int unsigned NUM_BA = 4;
  localparam int unsigned NUM_BANKS = NUM_BG * NUM_BA;
  localparam int unsigned ROW_W = 18;
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DEBT_W = 7;
  localparam logic [15:0] RST_TRP = 16'h000B;
  localparam logic [15:0] RST_TRFC = 16'h000D;
  localparam logic [15:0] RST_TWRDATA = 16'h0008;
  localparam logic [15:0] RST_TRAS = 16'h000D;
  localparam logic [15:0] RST_TREFI = 16'h0138;
  localparam logic [1:0] REF_MODE_1X = 2'h0;
  localparam logic [1:0] REF_MODE_2X = 2'h1;
  localparam logic [1:0] REF_MODE_4X = 2'h2;

  typedef enum logic [2:0] {
    DBAPR_CMD_DES = 3'h0,
    DBAPR_CMD_ACT = 3'h1,
    DBAPR_CMD_PRE = 3'h2,
    DBAPR_CMD_REF = 3'h3,
    DBAPR_CMD_RD = 3'h4,
    DBAPR_CMD_WR = 3'h5,
    DBAPR_CMD_OTHER = 3'h6
  } dbapr_cmd_e;

  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [ROW_W-1:0] addr;
  } dbapr_ca_s;

  typedef struct packed {
    logic [15:0] trp;
    logic [15:0] trfc;
    logic [15:0] twr_data;
    logic [15:0] tras;
    logic [15:0] trefi;
    logic [1:0] ref_mode;
  } dbapr_timing_s;

  typedef enum logic [1:0] {
    DBAPR_BK_IDLE = 2'h0,
    DBAPR_BK_OPEN = 2'h1,
    DBAPR_BK_APWAIT = 2'h3,
    DBAPR_BK_PRECHG = 2'h2
  } dbapr_bank_e;
endpackage

// ---- logic/dbapr_row_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// open row per bank; read data registered
module dbapr_row_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned WIDTH = 18
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2) $error("depth too small");
  end

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ---- logic/dbapr_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] activate opens row chosen by bank group, bank and 18-bit row.
// [RULE2] controller keeps row open until precharge; precharge before new row.
// [RULE3] activates to different bank groups spaced at least tRRD_S.
// [RULE4] activates within one bank group spaced at least tRRD_L.
// [RULE5] at most four activates in any rolling tFAW window.
// [RULE6] no activate to a bank until tRP after its precharge.
// [RULE7] read/write to other bank allowed while one bank auto-precharges.
// [RULE8] precharged bank is idle; activate before read or write.
// [RULE9] precharge accepted on idle/precharging bank; last one sets timing.
// [RULE10] address bit 10 high on read/write engages auto precharge.
// [RULE11] auto precharge held off until array restore completes.
// [RULE12] write auto precharge starts only after last write data stored.
// [RULE13] refresh: cs, ras, cas low and we high at rising edge.
// [RULE14] all banks precharged and idle tRP before refresh.
// [RULE15] refresh rows internal, address ignored, all banks idle after.
// [RULE16] only deselects until tRFC after refresh.
// [RULE17] one refresh per need, average spacing tREFI.
// [RULE18] at most 8/16/32 refreshes postponed in 1x/2x/4x.
// [RULE19] gap never above 9/17/33 intervals in 1x/2x/4x.
// [RULE20] up to 8/16/32 refreshes pulled in, each cancels one later.
// [RULE21] pulled-in beyond maximum cancels nothing further.
// [RULE22] 1x: no more than 16 extra refreshes in two tREFI.
// [RULE23] 2x and 4x modes refresh at twice and four times base rate.
// [RULE24] timing counts configurable; open/idle tracked per bank.
module dbapr_core
  import dbapr_pkg::*;
#(
  parameter int unsigned BANKS = dbapr_pkg::NUM_BANKS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire dbapr_pkg::dbapr_ca_s ca,
  input wire dbapr_pkg::dbapr_timing_s timing,
  output logic [BANKS-1:0] bank_open,
  output logic [BANKS-1:0] bank_busy,
  output logic [dbapr_pkg::ROW_W-1:0] open_row,
  output logic refresh_active,
  output logic [15:0] refresh_row,
  output logic [dbapr_pkg::DEBT_W-1:0] refresh_credit,
  output logic refresh_done
);
  import dbapr_pkg::*;

  localparam int unsigned BW = $clog2(BANKS);

  initial begin
    if (BANKS != NUM_BANKS) $error("bank count must match package");
  end

  dbapr_cmd_e cmd;
  logic [BW-1:0] bank_idx;
  dbapr_bank_e bank_state_reg [BANKS];
  logic [15:0] bank_cnt_reg [BANKS];
  logic [15:0] rfc_cnt_reg;
  logic [15:0] refi_cnt_reg;
  logic [DEBT_W-1:0] credit_reg;
  logic [15:0] refresh_row_reg;
  logic refresh_active_reg;
  logic refresh_done_reg;

  function automatic dbapr_cmd_e decode(input dbapr_ca_s c);
    dbapr_cmd_e r;
    r = DBAPR_CMD_OTHER;
    if (c.cs_n) begin
      r = DBAPR_CMD_DES;
    end else if (!c.act_n) begin
      r = DBAPR_CMD_ACT;
    end else begin
      unique case ({c.ras_n, c.cas_n, c.we_n})
        3'b001: r = DBAPR_CMD_REF;
        3'b010: r = DBAPR_CMD_PRE;
        3'b101: r = DBAPR_CMD_RD;
        3'b100: r = DBAPR_CMD_WR;
        default: r = DBAPR_CMD_OTHER;
      endcase
    end
    return r;
  endfunction

  // pulled-in limit in refreshes: 8, 16 or 32 by mode
  function automatic logic [DEBT_W-1:0] credit_max(input logic [1:0] m);
    logic [DEBT_W-1:0] r;
    r = 7'h08;
    if (m == REF_MODE_2X) r = 7'h10;
    if (m == REF_MODE_4X) r = 7'h20;
    return r;
  endfunction

  // interval shrinks with mode: tREFI, /2, /4
  function automatic logic [15:0] refi_len(input logic [15:0] base,
                                           input logic [1:0] m);
    logic [15:0] r;
    r = base;
    if (m == REF_MODE_2X) r = base >> 1;
    if (m == REF_MODE_4X) r = base >> 2;
    return r;
  endfunction

  assign cmd = decode(ca); // see [RULE13]
  assign bank_idx = BW'({ca.bg, ca.ba}); // see [RULE1]

  // row store, written on activate
  dbapr_row_mem #(
    .DEPTH(BANKS),
    .WIDTH(ROW_W)
  ) u_rows (
    .mclk(mclk),
    // an activate to a busy bank is ignored, so its stored row must stay
    .wr_en(cmd == DBAPR_CMD_ACT && !refresh_active_reg &&
           !bank_busy[bank_idx]), // see [RULE2]
    .wr_addr(bank_idx),
    .wr_data(ca.addr), // see [RULE1]
    .rd_addr(bank_idx),
    .rd_data(open_row)
  );

  // per-bank state; the device trusts the controller for spacing rules
  // see [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE8] [RULE14]
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < BANKS; i++) begin
        bank_state_reg[i] <= DBAPR_BK_IDLE;
        bank_cnt_reg[i] <= 16'h0000;
      end
    end else if (refresh_active_reg) begin
      for (int i = 0; i < BANKS; i++) begin
        bank_state_reg[i] <= DBAPR_BK_IDLE; // see [RULE15]
        bank_cnt_reg[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < BANKS; i++) begin
        unique case (bank_state_reg[i])
          DBAPR_BK_IDLE: begin
            if (cmd == DBAPR_CMD_ACT && bank_idx == BW'(i)) begin
              bank_state_reg[i] <= DBAPR_BK_OPEN; // see [RULE1]
              bank_cnt_reg[i] <= timing.tras;
            end else if (cmd == DBAPR_CMD_PRE && bank_idx == BW'(i)) begin
              // precharge to an idle bank still starts a fresh tRP
              bank_state_reg[i] <= DBAPR_BK_PRECHG; // see [RULE9]
              bank_cnt_reg[i] <= timing.trp;
            end
          end
          DBAPR_BK_OPEN: begin
            if (bank_cnt_reg[i] != 16'h0000) begin
              bank_cnt_reg[i] <= bank_cnt_reg[i] - 16'h0001;
            end
            if (bank_idx == BW'(i) && cmd == DBAPR_CMD_PRE) begin
              bank_state_reg[i] <= DBAPR_BK_PRECHG;
              bank_cnt_reg[i] <= timing.trp;
            end else if (bank_idx == BW'(i) && ca.addr[AP_BIT] &&
                         (cmd == DBAPR_CMD_RD || cmd == DBAPR_CMD_WR)) begin
              // see [RULE10] [RULE7]
              bank_state_reg[i] <= DBAPR_BK_APWAIT;
              // writes wait for the final data word to land
              if (cmd == DBAPR_CMD_WR &&
                  timing.twr_data > bank_cnt_reg[i]) begin
                bank_cnt_reg[i] <= timing.twr_data; // see [RULE12]
              end
            end
          end
          DBAPR_BK_APWAIT: begin
            // restore lockout hides the precharge under the burst
            if (bank_cnt_reg[i] > 16'h0001) begin
              bank_cnt_reg[i] <= bank_cnt_reg[i] - 16'h0001; // see [RULE11]
            end else begin
              bank_state_reg[i] <= DBAPR_BK_PRECHG;
              bank_cnt_reg[i] <= timing.trp;
            end
          end
          DBAPR_BK_PRECHG: begin
            if (bank_idx == BW'(i) && cmd == DBAPR_CMD_PRE) begin
              bank_cnt_reg[i] <= timing.trp; // see [RULE9]
            end else if (bank_cnt_reg[i] > 16'h0001) begin
              bank_cnt_reg[i] <= bank_cnt_reg[i] - 16'h0001;
            end else begin
              bank_state_reg[i] <= DBAPR_BK_IDLE; // see [RULE6]
            end
          end
        endcase
      end
    end
  end

  always_comb begin
    for (int i = 0; i < BANKS; i++) begin
      bank_open[i] = bank_state_reg[i] == DBAPR_BK_OPEN; // see [RULE24]
      bank_busy[i] = bank_state_reg[i] != DBAPR_BK_IDLE;
    end
  end

  // refresh cycle: address ignored, internal row counter advances
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_active_reg <= 1'b0;
      rfc_cnt_reg <= 16'h0000;
      refresh_row_reg <= 16'h0000;
      refresh_done_reg <= 1'b0;
    end else begin
      refresh_done_reg <= 1'b0;
      if (!refresh_active_reg && cmd == DBAPR_CMD_REF) begin
        refresh_active_reg <= 1'b1; // see [RULE13] [RULE15]
        rfc_cnt_reg <= timing.trfc; // see [RULE16]
        refresh_row_reg <= refresh_row_reg + 16'h0001;
      end else if (refresh_active_reg) begin
        if (rfc_cnt_reg > 16'h0001) begin
          rfc_cnt_reg <= rfc_cnt_reg - 16'h0001;
        end else begin
          refresh_active_reg <= 1'b0;
          refresh_done_reg <= 1'b1;
        end
      end
    end
  end

  // credit: interval ticks take one, refreshes give one, clamped
  // to the pull-in ceiling so extras beyond it cancel nothing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refi_cnt_reg <= 16'h0000;
      credit_reg <= 7'h00;
    end else begin
      logic tick;
      logic took;
      tick = 1'b0;
      took = !refresh_active_reg && cmd == DBAPR_CMD_REF;
      if (refi_cnt_reg + 16'h0001 >= refi_len(timing.trefi, timing.ref_mode))
      begin
        refi_cnt_reg <= 16'h0000; // see [RULE17] [RULE23]
        tick = 1'b1;
      end else begin
        refi_cnt_reg <= refi_cnt_reg + 16'h0001;
      end
      if (took && !tick && credit_reg < credit_max(timing.ref_mode)) begin
        credit_reg <= credit_reg + 7'h01; // see [RULE20] [RULE21] [RULE22]
      end else if (tick && !took && credit_reg != 7'h00) begin
        credit_reg <= credit_reg - 7'h01; // see [RULE18] [RULE19]
      end
    end
  end

  assign refresh_active = refresh_active_reg;
  assign refresh_row = refresh_row_reg;
  assign refresh_credit = credit_reg;
  assign refresh_done = refresh_done_reg;
endmodule
`default_nettype wire

// ---- test/dbapr_core_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module dbapr_core_asserts #(parameter int unsigned BANKS = 16) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire dbapr_pkg::dbapr_ca_s ca,
  input wire dbapr_pkg::dbapr_timing_s timing,
  input wire logic [BANKS-1:0] bank_open,
  input wire logic [BANKS-1:0] bank_busy,
  input wire logic [dbapr_pkg::ROW_W-1:0] open_row,
  input wire logic refresh_active,
  input wire logic [15:0] refresh_row,
  input wire logic [dbapr_pkg::DEBT_W-1:0] refresh_credit,
  input wire logic refresh_done
);
  import dbapr_pkg::*;
  wire logic [3:0] idx = {ca.bg, ca.ba};
  wire logic [2:0] op = {ca.ras_n, ca.cas_n, ca.we_n};
  wire logic act = !ca.cs_n && !ca.act_n;
  wire logic pre = !ca.cs_n && ca.act_n && op == 3'h2;
  wire logic refc = !ca.cs_n && ca.act_n && op == 3'h1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_act_opens: assert property (act && !bank_busy[idx] && !refresh_active
    |=> bank_open[$past(idx)]) else $error("activate did not open bank");
  a_act_refused: assert property (act && bank_busy[idx]
    |=> bank_open[$past(idx)] == $past(bank_open[idx]))
    else $error("activate to busy bank changed it");
  a_pre_closes: assert property (pre && !refresh_active
    |=> !bank_open[$past(idx)] && bank_busy[$past(idx)])
    else $error("precharge did not close bank");
  a_ref_starts: assert property (refc && !refresh_active
    |=> refresh_active && refresh_row == $past(refresh_row) + 16'h0001)
    else $error("refresh did not start");
  a_ref_ignored: assert property (refc && refresh_active
    |=> $stable(refresh_row)) else $error("refresh taken during refresh");
  a_ref_blocks: assert property (refresh_active && act
    |=> !bank_open[$past(idx)]) else $error("activate taken in refresh");
  a_ref_idle: assert property ($fell(refresh_active)
    |-> bank_busy == '0) else $error("bank busy after refresh");
  a_done_pulse: assert property (refresh_done
    |=> !refresh_done && !refresh_active) else $error("done not a pulse");
  a_credit_cap: assert property (refresh_credit <= 7'h20)
    else $error("credit above maximum");
endmodule
bind dbapr_core dbapr_core_asserts #(.BANKS(BANKS)) chk_i (.mclk(mclk),
  .rst_n(rst_n), .ca(ca), .timing(timing), .bank_open(bank_open),
  .bank_busy(bank_busy), .open_row(open_row),
  .refresh_active(refresh_active), .refresh_row(refresh_row),
  .refresh_credit(refresh_credit), .refresh_done(refresh_done));
`default_nettype wire

// ---- test/dbapr_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dbapr_ctrl_model (
  input wire logic mclk,
  output var dbapr_pkg::dbapr_ca_s ca
);
  import dbapr_pkg::*;
  initial ca = '{cs_n: 1'h1, default: '0};
  // caller keeps tRP, tRFC and tRRD gaps
  task automatic cmd(input dbapr_cmd_e k, input logic [3:0] b,
                     input logic [17:0] a);
    dbapr_ca_s c;
    c = '{cs_n: 1'h0, act_n: k != DBAPR_CMD_ACT, bg: b[3:2], ba: b[1:0],
          addr: a, default: '0};
    case (k)
      DBAPR_CMD_REF: {c.ras_n, c.cas_n, c.we_n} = 3'h1;
      DBAPR_CMD_PRE: {c.ras_n, c.cas_n, c.we_n} = 3'h2;
      DBAPR_CMD_RD: {c.ras_n, c.cas_n, c.we_n} = 3'h5;
      DBAPR_CMD_WR: {c.ras_n, c.cas_n, c.we_n} = 3'h4;
      default: {c.ras_n, c.cas_n, c.we_n} = 3'h7;
    endcase
    @(posedge mclk);
    ca <= c;
    @(posedge mclk);
    // bank lines stay put so open_row keeps showing this bank
    ca.cs_n <= 1'h1;
  endtask
endmodule
`default_nettype wire

// ---- test/test_ddr4_bank_activate_precharge_refresh.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_ddr4_bank_activate_precharge_refresh;
  import dbapr_pkg::*;
  localparam int TRP = 4;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  dbapr_ca_s ca;
  dbapr_timing_s timing = '{16'h0004, 16'h0008, 16'h0006, 16'h0008,
                            16'h4000, 2'h0};
  logic [15:0] bank_open;
  logic [15:0] bank_busy;
  logic [17:0] open_row;
  logic refresh_active;
  logic refresh_done;
  logic [15:0] refresh_row;
  logic [6:0] refresh_credit;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 67;
  int nref = 0;
  int credit = 0;
  logic [15:0] mopen = '0;
  logic [17:0] mrow [16];
  initial forever #12.5 mclk = ~mclk;
  dbapr_core dbapr_core_i (.mclk(mclk), .rst_n(rst_n), .ca(ca),
    .timing(timing), .bank_open(bank_open), .bank_busy(bank_busy),
    .open_row(open_row), .refresh_active(refresh_active),
    .refresh_row(refresh_row), .refresh_credit(refresh_credit),
    .refresh_done(refresh_done));
  dbapr_ctrl_model dbapr_ctrl_model_i (.mclk(mclk), .ca(ca));
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cmd(input dbapr_cmd_e k, input int b, input logic [17:0] a);
    dbapr_ctrl_model_i.cmd(k, b[3:0], a);
    #1;
  endtask
  // bounded waits: a stuck bank or refresh shows as a mismatch
  task automatic wait_idle(input int b);
    for (int n = 0; n < 60 && bank_busy[b] !== 1'h0; n++) tick(1);
    chk("bank_busy", bank_busy[b], 1'h0);
  endtask
  task automatic wait_done();
    for (int n = 0; n < 60 && refresh_done !== 1'h1; n++) tick(1);
    chk("refresh_done", refresh_done, 1'h1);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    int b;
    logic [17:0] r;
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    tick(1);
    for (int i = 0; i < 6; i++) begin
      b = $unsigned($random(seed)) % 16;
      r = $random(seed);
      cmd(DBAPR_CMD_ACT, b, r);
      if (!mopen[b]) begin
        mopen[b] = 1'h1;
        mrow[b] = r;
      end
      chk("bank_open", bank_open, mopen);
      tick(1);
      chk("open_row", open_row, mrow[b]);
    end
    for (int i = 0; i < 16; i++) begin
      if (mopen[i]) begin
        cmd(DBAPR_CMD_PRE, i, 18'h0);
        mopen[i] = 1'h0;
        chk("bank_busy", bank_busy[i], 1'h1);
      end
    end
    chk("bank_open", bank_open, mopen);
    tick(TRP + 2);
    chk("bank_busy", bank_busy, 16'h0);
    $display("test activate done");
    cmd(DBAPR_CMD_PRE, 0, 18'h0);
    chk("bank_busy", bank_busy[0], 1'h1);
    tick(2);
    cmd(DBAPR_CMD_PRE, 0, 18'h0);
    tick(TRP - 1);
    chk("bank_busy", bank_busy[0], 1'h1);
    wait_idle(0);
    $display("test precharge done");
    cmd(DBAPR_CMD_ACT, 5, 18'h1);
    cmd(DBAPR_CMD_ACT, 9, 18'h2);
    cmd(DBAPR_CMD_RD, 5, 18'h0400);
    cmd(DBAPR_CMD_RD, 9, 18'h0);
    cmd(DBAPR_CMD_ACT, 9, 18'h7);
    wait_idle(5);
    chk("bank_open", bank_open[9], 1'h1);
    cmd(DBAPR_CMD_ACT, 5, 18'h3);
    cmd(DBAPR_CMD_WR, 5, 18'h0400);
    tick(5);
    chk("bank_busy", bank_busy[5], 1'h1);
    wait_idle(5);
    cmd(DBAPR_CMD_PRE, 9, 18'h0);
    wait_idle(9);
    $display("test auto precharge done");
    cmd(DBAPR_CMD_REF, 0, 18'h3_ffff);
    nref++;
    credit++;
    chk("refresh_active", refresh_active, 1'h1);
    chk("refresh_row", refresh_row, nref);
    cmd(DBAPR_CMD_REF, 0, 18'h0);
    cmd(DBAPR_CMD_ACT, 3, 18'h0);
    chk("refresh_row", refresh_row, nref);
    chk("bank_open", bank_open, 16'h0);
    wait_done();
    chk("bank_busy", bank_busy, 16'h0);
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk);
      timing.ref_mode <= m[1:0];
      for (int i = 0; i < ((m == 2) ? 20 : 10); i++) begin
        cmd(DBAPR_CMD_REF, 0, 18'h0);
        nref++;
        credit = (credit + 1 > (8 << m)) ? (8 << m) : credit + 1;
        wait_done();
      end
      chk("refresh_credit", refresh_credit, credit);
      chk("refresh_row", refresh_row, nref);
    end
    $display("test refresh done");
    complete_run();
  end
endmodule
`default_nettype wire
